// ===== cbau_pkg.sv
// shared constants and types for the complement and decimal adjust datapath
package cbau_pkg;

	////////////////////////////////////////////////////////////////////////////
	// operation selects presented by the instruction decoder
	typedef enum logic [1:0]
	{
		op_none,
		op_invert_to_accumulator,
		op_invert_in_place,
		op_decimal_adjust_add
	} op_t;

	////////////////////////////////////////////////////////////////////////////
	// widths and decimal adjust constants
	localparam int DATA_W = 8;
	localparam logic [3:0] NIBBLE_MAX = 4'h9;
	localparam logic [7:0] ADJ_NONE = 8'h00;
	localparam logic [7:0] ADJ_LOW = 8'h06;
	localparam logic [7:0] ADJ_HIGH = 8'h60;
	localparam logic [7:0] ADJ_BOTH = 8'h66;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// registered result state of the unit
	typedef struct packed
	{
		logic acc_wr_en;
		logic [7:0] acc_wdata;
		logic mem_wr_en;
		logic [7:0] mem_wdata;
		logic zero_wr_en;
		logic zero_out;
		logic carry_wr_en;
		logic carry_out;
	} unit_state_t;

	// value after reset: no writes requested, all data and flags low
	localparam unit_state_t STATE_RESET = '{
		acc_wr_en: 1'b0,
		acc_wdata: 8'h00,
		mem_wr_en: 1'b0,
		mem_wdata: 8'h00,
		zero_wr_en: 1'b0,
		zero_out: 1'b0,
		carry_wr_en: 1'b0,
		carry_out: 1'b0
	};

endpackage : cbau_pkg

// ===== adjust_if.sv
`timescale 1ns/1ps
`default_nettype none
// carries the operand and flags into the decimal adjust core and the answer back
interface adjust_if;
	logic [7:0] operand;
	logic half_carry;
	logic carry;
	logic [7:0] correction;
	logic [7:0] result;
	logic carry_result;

	modport requester
	(
		output operand,
		output half_carry,
		output carry,
		input correction,
		input result,
		input carry_result
	);

	modport adjuster
	(
		input operand,
		input half_carry,
		input carry,
		output correction,
		output result,
		output carry_result
	);
endinterface : adjust_if
`default_nettype wire

// ===== decimal_adjust_core.sv
`timescale 1ns/1ps
`default_nettype none
// purely combinational bcd correction of an accumulator value
module decimal_adjust_core
	import cbau_pkg::*;
(
	adjust_if.adjuster adj
);

	logic low_fix;
	logic high_fix;
	logic [8:0] low_sum;
	logic [8:0] full_sum;
	logic [7:0] corr;

	////////////////////////////////////////////////////////////////////////////
	// high nibble is judged after the low fix so a ripple into it is seen
	always_comb
	begin
		low_fix = (adj.operand[3:0] > NIBBLE_MAX) | adj.half_carry;
		low_sum = {1'b0, adj.operand} + {1'b0, (low_fix ? ADJ_LOW : ADJ_NONE)};
		high_fix = (low_sum[7:4] > NIBBLE_MAX) | adj.carry | low_sum[8];
		corr = (low_fix ? ADJ_LOW : ADJ_NONE) | (high_fix ? ADJ_HIGH : ADJ_NONE);
		full_sum = {1'b0, adj.operand} + {1'b0, corr};
	end

	// carry only ever set here, never cleared, so a chained sum keeps it
	assign adj.correction = corr;
	assign adj.result = full_sum[7:0];
	assign adj.carry_result = adj.carry | full_sum[8];

endmodule : decimal_adjust_core
`default_nettype wire

// ===== complement_and_bcd_adjust_unit.sv
`timescale 1ns/1ps
`default_nettype none
module complement_and_bcd_adjust_unit
	import cbau_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic op_valid,
	input wire op_t op_sel,
	input wire logic [7:0] mem_rdata,
	input wire logic [7:0] acc_in,
	input wire logic carry_in,
	input wire logic half_carry_flag,
	output logic acc_wr_en,
	output logic [7:0] acc_wdata,
	output logic mem_wr_en,
	output logic [7:0] mem_wdata,
	output logic zero_wr_en,
	output logic zero_out,
	output logic carry_wr_en,
	output logic carry_out
);

	unit_state_t state;
	unit_state_t next_state;
	logic [7:0] inverted;
	logic take_inv_acc;
	logic take_inv_mem;
	logic take_daa;

	adjust_if adj ();

	////////////////////////////////////////////////////////////////////////////
	// decimal adjust core sees the accumulator and current flags directly
	assign adj.operand = acc_in;
	assign adj.half_carry = half_carry_flag;
	assign adj.carry = carry_in;

	decimal_adjust_core u_adjust
	(
		.adj(adj.adjuster)
	);

	////////////////////////////////////////////////////////////////////////////
	// operation decode, a request counts only while op_valid is high
	assign take_inv_acc = op_valid && (op_sel == op_invert_to_accumulator);
	assign take_inv_mem = op_valid && (op_sel == op_invert_in_place);
	assign take_daa = op_valid && (op_sel == op_decimal_adjust_add);

	// one's complement shared by both invert operations
	assign inverted = ~mem_rdata;

	////////////////////////////////////////////////////////////////////////////
	// next result: a write strobe is high one cycle per accepted request that writes it, the data and
	// flag values hold until the next accepted operation so a slow consumer
	// can still sample them after the strobe has dropped
	always_comb
	begin
		next_state = state;
		next_state.acc_wr_en = 1'b0;
		next_state.mem_wr_en = 1'b0;
		next_state.zero_wr_en = 1'b0;
		next_state.carry_wr_en = 1'b0;
		case (op_sel)
			op_invert_to_accumulator:
			begin
				if (op_valid)
				begin
					next_state.acc_wr_en = 1'b1;
					next_state.acc_wdata = inverted;
					next_state.zero_wr_en = 1'b1;
					next_state.zero_out = (inverted == BYTE_ZERO);
				end
			end
			op_invert_in_place:
			begin
				if (op_valid)
				begin
					next_state.mem_wr_en = 1'b1;
					next_state.mem_wdata = inverted;
					next_state.zero_wr_en = 1'b1;
					next_state.zero_out = (inverted == BYTE_ZERO);
				end
			end
			op_decimal_adjust_add:
			begin
				if (op_valid)
				begin
					// zero flag deliberately not written here
					next_state.mem_wr_en = 1'b1;
					next_state.mem_wdata = adj.result;
					next_state.carry_wr_en = 1'b1;
					next_state.carry_out = adj.carry_result;
				end
			end
			default:
			begin
				next_state = next_state;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// single register stage, synchronous reset
	always_ff @(posedge mclk)
	begin
		if (rst)
			state <= STATE_RESET;
		else
			state <= next_state;
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs come straight from the state register
	assign acc_wr_en = state.acc_wr_en;
	assign acc_wdata = state.acc_wdata;
	assign mem_wr_en = state.mem_wr_en;
	assign mem_wdata = state.mem_wdata;
	assign zero_wr_en = state.zero_wr_en;
	assign zero_out = state.zero_out;
	assign carry_wr_en = state.carry_wr_en;
	assign carry_out = state.carry_out;

	////////////////////////////////////////////////////////////////////////////
	// checks, all on mclk and quiet during reset
	default clocking cb @(posedge mclk);
	endclocking

	default disable iff (rst);

	// helper: accumulator seen at the previous edge, kept in clocked code so the
	// correction checks can subtract it from the byte written one edge later
	logic [7:0] acc_prev;
	always_ff @(posedge mclk)
	begin
		acc_prev <= acc_in;
	end

	// helper: correction the unit actually applied on the last decimal adjust
	logic [7:0] applied_corr;
	assign applied_corr = mem_wdata - acc_prev;

	// inverted memory byte lands in the accumulator one edge later
	chk_inv_acc_data: assert property (
		take_inv_acc |=> acc_wr_en && (acc_wdata == ~$past(mem_rdata))
	)
	else $error("invert to accumulator result wrong");

	// invert-to-accumulator must not disturb the memory location
	chk_inv_acc_nomem: assert property (
		take_inv_acc |=> !mem_wr_en
	)
	else $error("memory written during invert to accumulator");

	// invert-to-accumulator raises the accumulator strobe, which drops a cycle later unless op_valid was still high
	chk_inv_acc_dest: assert property (
		take_inv_acc |=> acc_wr_en ##1 !acc_wr_en || $past(op_valid)
	)
	else $error("accumulator strobe not a single pulse");

	// in-place invert writes memory, never the accumulator
	chk_inv_mem_dest: assert property (
		take_inv_mem |=> mem_wr_en && !acc_wr_en && (mem_wdata == ~$past(mem_rdata))
	)
	else $error("in-place invert result wrong");

	// zero flag follows the complemented byte only
	chk_zero_flag: assert property (
		(take_inv_acc || take_inv_mem) |=> zero_wr_en && !carry_wr_en
			&& (zero_out == ($past(mem_rdata) == 8'hFF))
	)
	else $error("zero flag wrong after complement");

	// decimal adjust goes to memory and only touches carry
	chk_daa_dest: assert property (
		take_daa |=> mem_wr_en && !acc_wr_en && !zero_wr_en && carry_wr_en
	)
	else $error("decimal adjust destination or flags wrong");

	// a clean low digit with no half carry passes through unchanged
	chk_daa_low_keep: assert property (
		take_daa && (acc_in[3:0] <= 4'h9) && !half_carry_flag
			|=> mem_wdata[3:0] == $past(acc_in[3:0])
	)
	else $error("low nibble altered without cause");

	// a bad low digit or a half carry always brings in the low six
	chk_daa_low_fix: assert property (
		take_daa && ((acc_in[3:0] > 4'h9) || half_carry_flag)
			|=> applied_corr[3:0] == 4'h6
	)
	else $error("low nibble not corrected");

	// an invalid high digit must produce a decimal carry
	chk_daa_high_fix: assert property (
		take_daa && (acc_in[7:4] > 4'h9) |=> carry_out
	)
	else $error("high nibble over nine gave no carry");

	// correction constant is one of the four permitted values
	chk_daa_corr_set: assert property (
		take_daa |=> applied_corr inside {8'h00, 8'h06, 8'h60, 8'h66}
	)
	else $error("decimal correction outside permitted set");

	// an incoming carry is never lost across the adjust
	chk_daa_carry: assert property (
		take_daa && carry_in |=> carry_out ##1 (carry_out || $past(op_valid))
	)
	else $error("carry dropped by decimal adjust");

	// main scenarios
	cov_inv_acc_zero: cover property (take_inv_acc && (mem_rdata == 8'hFF));
	cov_inv_mem: cover property (take_inv_mem ##1 take_inv_mem);
	cov_daa_both: cover property (take_daa && (adj.correction == ADJ_BOTH));
	cov_daa_carry: cover property (take_daa && !carry_in && adj.carry_result);

endmodule : complement_and_bcd_adjust_unit
`default_nettype wire

// ===== cbau_partner.sv
`timescale 1ns/1ps
`default_nettype none
// decoder side stand-in: one addressed memory byte and the accumulator
module cbau_partner
(
	input wire logic mclk,
	input wire logic load,
	input wire logic [7:0] load_mem,
	input wire logic [7:0] load_acc,
	input wire logic acc_wr_en,
	input wire logic [7:0] acc_wdata,
	input wire logic mem_wr_en,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata,
	output logic [7:0] acc_in
);
	// a preload wins over a write strobe, so the bench can reseed at any cycle
	always_ff @(posedge mclk)
	begin
		if (load)
		begin
			mem_rdata <= load_mem;
			acc_in <= load_acc;
		end
		else
		begin
			if (mem_wr_en) mem_rdata <= mem_wdata;
			if (acc_wr_en) acc_in <= acc_wdata;
		end
	end
endmodule : cbau_partner
`default_nettype wire

// ===== tb_complement_and_bcd_adjust_unit.sv
`timescale 1ns/1ps
`default_nettype none
// driver notes expected results, watcher compares them on each write strobe
module tb_complement_and_bcd_adjust_unit
	import cbau_pkg::*;
;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic op_valid = 1'b0;
	op_t op_sel = op_none;
	logic carry_in = 1'b0;
	logic half_carry_flag = 1'b0;
	logic load = 1'b0;
	logic [7:0] load_mem = 8'h00;
	logic [7:0] load_acc = 8'h00;
	logic [7:0] mem_rdata, acc_in, acc_wdata, mem_wdata;
	logic acc_wr_en, mem_wr_en, zero_wr_en, zero_out, carry_wr_en, carry_out;
	unit_state_t q[$];
	unit_state_t last = STATE_RESET;
	unit_state_t w;
	logic [7:0] sm = 8'h00;
	logic [7:0] sa = 8'h00;
	logic [7:0] dv[6] = '{8'h99, 8'h45, 8'hA2, 8'h9A, 8'hFF, 8'h00};
	logic [5:0] dc = 6'b100000;
	logic [5:0] dh = 6'b100010;
	int err_total = 0;
	int n_checks = 0;

	complement_and_bcd_adjust_unit dut_u (.mclk, .rst, .op_valid, .op_sel, .mem_rdata, .acc_in,
		.carry_in, .half_carry_flag, .acc_wr_en, .acc_wdata, .mem_wr_en, .mem_wdata,
		.zero_wr_en, .zero_out, .carry_wr_en, .carry_out);
	cbau_partner partner_u (.mclk, .load, .load_mem, .load_acc, .acc_wr_en, .acc_wdata,
		.mem_wr_en, .mem_wdata, .mem_rdata, .acc_in);

	initial
	begin
		forever #25 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("FAIL %0t got %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done

	// expected outputs; unwritten data fields keep their previous value
	task automatic note(input op_t op, input logic c, input logic h);
		unit_state_t e;
		logic lo, hi;
		logic [8:0] t;
		logic [7:0] r;
		e = last;
		r = ~sm;
		lo = (sa[3:0] > 4'h9) | h;
		t = {1'b0, sa} + (lo ? 9'h006 : 9'h000);
		hi = (t[7:4] > 4'h9) | c | t[8];
		t = {1'b0, sa} + {1'b0, hi ? 4'h6 : 4'h0, lo ? 4'h6 : 4'h0};
		e.acc_wr_en = (op == op_invert_to_accumulator);
		e.mem_wr_en = !e.acc_wr_en;
		e.zero_wr_en = (op != op_decimal_adjust_add);
		e.carry_wr_en = !e.zero_wr_en;
		if (e.zero_wr_en) e.zero_out = (r == 8'h00);
		if (e.acc_wr_en) e.acc_wdata = r;
		if (e.acc_wr_en) sa = r;
		else if (e.zero_wr_en) e.mem_wdata = r;
		else e.mem_wdata = t[7:0];
		if (e.carry_wr_en) e.carry_out = c | t[8];
		if (e.mem_wr_en) sm = e.mem_wdata;
		last = e;
		q.push_back(e);
	endtask : note

	// one request: optional preload, then op_valid raised and left high until the next step drops it
	task automatic step(input logic ld, input logic v, input op_t op, input logic [7:0] m,
		input logic [7:0] a, input logic c, input logic h);
		@(posedge mclk);
		op_valid <= 1'b0;
		load <= ld;
		load_mem <= m;
		load_acc <= a;
		if (ld) sm = m;
		if (ld) sa = a;
		@(posedge mclk);
		load <= 1'b0;
		op_valid <= v;
		op_sel <= op;
		carry_in <= c;
		half_carry_flag <= h;
		if (v && op != op_none) note(op, c, h);
	endtask : step

	////////////////////////////////////////////////////////////////////////////
	// watcher: takes the oldest note whenever any write strobe shows
	always @(posedge mclk)
	begin
		if (!rst && (acc_wr_en | mem_wr_en | zero_wr_en | carry_wr_en))
		begin
			w = (q.size() > 0) ? q.pop_front() : STATE_RESET;
			check({4'h0, acc_wr_en, mem_wr_en, zero_wr_en, carry_wr_en},
				{4'h0, w.acc_wr_en, w.mem_wr_en, w.zero_wr_en, w.carry_wr_en});
			check(acc_wdata, w.acc_wdata);
			check(mem_wdata, w.mem_wdata);
			check({6'h00, zero_out, carry_out}, {6'h00, w.zero_out, w.carry_out});
		end
	end

	initial
	begin
		void'($urandom(32'h2068447b));
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		// each correction value, then read back the written byte without reloading
		for (int i = 0; i < 6; i++)
		begin
			step(1'b1, 1'b1, op_decimal_adjust_add, 8'h3C, dv[i], dc[i], dh[i]);
			step(1'b0, 1'b1, op_invert_to_accumulator, 8'h00, 8'h00, 1'b0, 1'b0);
		end
		// zero flag corners, in place twice to see the write land in memory
		for (int i = 0; i < 2; i++)
		begin
			step(1'b1, 1'b1, op_invert_in_place, i[0] ? 8'hFF : 8'h00, 8'h11, 1'b1, 1'b0);
			step(1'b0, 1'b1, op_invert_in_place, 8'h00, 8'h00, 1'b0, 1'b1);
		end
		// back-to-back burst must leave memory alone
		step(1'b1, 1'b1, op_invert_to_accumulator, 8'h5A, 8'h00, 1'b0, 1'b0);
		repeat (2)
		begin
			@(posedge mclk);
			note(op_invert_to_accumulator, 1'b0, 1'b0);
		end
		step(1'b0, 1'b0, op_none, 8'h00, 8'h00, 1'b0, 1'b0);
		repeat (2) @(posedge mclk);
		check(mem_rdata, 8'h5A);
		repeat (80)
			step($urandom_range(0, 3) != 0, $urandom_range(0, 5) != 0,
				op_t'($urandom_range(0, 3)), 8'($urandom), 8'($urandom),
				1'($urandom), 1'($urandom));
		step(1'b0, 1'b0, op_none, 8'h00, 8'h00, 1'b0, 1'b0);
		repeat (10) if (q.size() > 0) @(posedge mclk);
		check(8'(q.size()), 8'h00);
		test_done();
	end
endmodule : tb_complement_and_bcd_adjust_unit
`default_nettype wire
